// File: reset_init_pkg.sv
// constants for the reset state initializer
package reset_init_pkg;
  localparam logic [15:0] PC_NORMAL_RST   = 16'hfffe;
  localparam logic [15:0] PC_SERIAL_RST   = 16'h1ffe;
  localparam logic [15:0] SP_RST          = 16'h00ff;
  localparam logic [15:0] VEC_LO_ADDR     = 16'hfffe;
  localparam logic [15:0] VEC_HI_ADDR     = 16'hffff;
  localparam int          WARMUP_CYCLES   = 16;
  localparam int          PORT_WIDTH      = 8;
  localparam int          PRESCALE_WIDTH  = 8;
  localparam int          ENABLE_WIDTH    = 8;
  localparam int          LATCH_WIDTH     = 8;
  localparam logic [1:0]  REG_CTRL        = 2'h0;
  localparam logic [1:0]  REG_STATUS      = 2'h1;
  localparam logic [1:0]  REG_PC          = 2'h2;
  localparam logic [1:0]  REG_VDET        = 2'h3;
  localparam int          CTRL_LFOSC_BIT  = 0;
  localparam int          CTRL_VDET_BIT   = 1;
  typedef enum logic [2:0] {
    ST_RESET  = 3'b001,
    ST_WARMUP = 3'b010,
    ST_RUN    = 3'b100
  } phase_t;
endpackage

// File: warmup_counter.sv
// warm-up counter on the high-frequency clock
`timescale 1ns/1ps
module warmup_counter #(
  parameter int COUNT = 16
) (
  input  wire logic sys_clk,
  input  wire logic clear,
  input  wire logic run,
  output logic      done
);
  localparam int W = $clog2(COUNT + 1);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic         done_r;
  logic         done_nxt;

  always_comb begin
    count_nxt = count_r;
    done_nxt  = 1'b0;
    if (clear) begin
      count_nxt = '0;
    end else if (run && count_r != W'(COUNT)) begin
      count_nxt = count_r + 1'b1;
      done_nxt  = (count_r == W'(COUNT - 1));
    end
  end

  always_ff @(posedge sys_clk) begin
    count_r <= count_nxt;
    done_r  <= done_nxt;
  end

  assign done = done_r;
endmodule

// File: reset_state_initializer.sv
// reset, warm-up and release sequencing of core and peripheral state
//
// The register addresses and strobed register access were left to the implementer.
`timescale 1ns/1ps
module reset_state_initializer
  import reset_init_pkg::*;
#(
  parameter int WARMUP = WARMUP_CYCLES
) (
  input  wire logic                      sys_clk,
  input  wire logic                      reset_n,
  input  wire logic                      powerOnReset,
  input  wire logic                      pinReset,
  input  wire logic                      internalReset,
  input  wire logic                      serialProgMode,
  input  wire logic [1:0]                regAddr,
  input  wire logic [15:0]               regWrData,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output logic      [15:0]               regRdData,
  output logic      [15:0]               programCounter,
  output logic      [15:0]               stackPointer,
  output logic                           registerBankSelect,
  output logic                           masterInterruptEnable,
  output logic      [ENABLE_WIDTH-1:0]   individualEnableFlags,
  output logic      [LATCH_WIDTH-1:0]    interruptLatch,
  output logic                           highOscEnable,
  output logic                           lowOscEnable,
  output logic                           watchdogEnable,
  output logic      [PRESCALE_WIDTH-1:0] prescaler,
  output logic                           voltDetectEnable,
  output logic                           cpuRun,
  output logic                           vectorFetch,
  output logic      [PORT_WIDTH-1:0]     portOutEnable
);
  // reset pins are asynchronous to sys_clk
  logic [2:0] rstMeta_r;
  logic [2:0] rstSync_r;
  logic       modeMeta_r;
  logic       modeSync_r;
  always_ff @(posedge sys_clk) begin
    rstMeta_r  <= {internalReset, pinReset, powerOnReset};
    rstSync_r  <= rstMeta_r;
    modeMeta_r <= serialProgMode;
    modeSync_r <= modeMeta_r;
  end
  wire logic anyReset  = ~reset_n | (|rstSync_r);
  wire logic hardReset = ~reset_n | rstSync_r[0] | rstSync_r[1];

  phase_t phase_r;
  phase_t phase_nxt;
  logic   warmDone;

  warmup_counter #(.COUNT(WARMUP)) u_warmup (
    .sys_clk (sys_clk),
    .clear   (anyReset || phase_r == ST_RESET),
    .run     (phase_r == ST_WARMUP),
    .done    (warmDone)
  );

  always_comb begin
    phase_nxt = phase_r;
    if (anyReset) begin
      phase_nxt = ST_RESET;
    end else begin
      case (phase_r)
        ST_RESET:  phase_nxt = ST_WARMUP;
        ST_WARMUP: if (warmDone) phase_nxt = ST_RUN;
        ST_RUN:    phase_nxt = ST_RUN;
        default:   phase_nxt = ST_RESET;
      endcase
    end
  end

  // held state; cpu owns these once released, modelled here as register writes
  logic        lowOsc_r, lowOsc_nxt;
  logic        vdet_r, vdet_nxt;
  logic [15:0] pc_r, pc_nxt;
  logic        vecFetch_r, vecFetch_nxt;
  logic        wdog_r, wdog_nxt;
  logic [15:0] rdData_r, rdData_nxt;
  logic        cpuRun_r, cpuRun_nxt;

  always_comb begin
    lowOsc_nxt   = lowOsc_r;
    vdet_nxt     = vdet_r;
    pc_nxt       = pc_r;
    vecFetch_nxt = 1'b0;
    wdog_nxt     = (phase_nxt == ST_RUN);
    cpuRun_nxt   = (phase_nxt == ST_RUN);
    rdData_nxt   = 16'h0000;
    if (hardReset) begin
      vdet_nxt = 1'b0;
    end else if (regWr && regAddr == REG_VDET) begin
      vdet_nxt = regWrData[0];
    end
    if (phase_nxt != ST_RUN) begin
      lowOsc_nxt = 1'b0;
      pc_nxt     = modeSync_r ? PC_SERIAL_RST : PC_NORMAL_RST;
    end else if (phase_r == ST_WARMUP) begin
      vecFetch_nxt = 1'b1;
    end else if (regWr && regAddr == REG_CTRL) begin
      lowOsc_nxt = regWrData[CTRL_LFOSC_BIT];
    end
    if (regRd) begin
      case (regAddr)
        REG_CTRL:   rdData_nxt = {14'h0, vdet_r, lowOsc_r};
        REG_STATUS: rdData_nxt = {13'h0, phase_r};
        REG_PC:     rdData_nxt = pc_r;
        REG_VDET:   rdData_nxt = {15'h0, vdet_r};
        default:    rdData_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      phase_r    <= ST_RESET;
      lowOsc_r   <= 1'b0;
      vdet_r     <= 1'b0;
      // the mode strap still picks the vector while held in reset
      pc_r       <= pc_nxt;
      vecFetch_r <= 1'b0;
      wdog_r     <= 1'b0;
      cpuRun_r   <= 1'b0;
      rdData_r   <= 16'h0000;
    end else begin
      phase_r    <= phase_nxt;
      lowOsc_r   <= lowOsc_nxt;
      vdet_r     <= vdet_nxt;
      pc_r       <= pc_nxt;
      vecFetch_r <= vecFetch_nxt;
      wdog_r     <= wdog_nxt;
      cpuRun_r   <= cpuRun_nxt;
      rdData_r   <= rdData_nxt;
    end
  end

  // fixed values: ram, general registers and flags deliberately get no reset
  logic [15:0] sp_r;
  always_ff @(posedge sys_clk) begin
    sp_r <= SP_RST;
  end

  assign regRdData             = rdData_r;
  assign programCounter        = pc_r;
  assign stackPointer          = sp_r;
  assign registerBankSelect    = 1'b0;
  assign masterInterruptEnable = 1'b0;
  assign individualEnableFlags = '0;
  assign interruptLatch        = '0;
  assign highOscEnable         = 1'b1;
  assign lowOscEnable          = lowOsc_r;
  assign watchdogEnable        = wdog_r;
  assign prescaler             = '0;
  assign voltDetectEnable      = vdet_r;
  assign cpuRun                = cpuRun_r;
  assign vectorFetch           = vecFetch_r;
  assign portOutEnable         = '0;

  property p_pc_held;
    @(posedge sys_clk) disable iff (!reset_n)
      (phase_r != ST_RUN) |=> (pc_r == PC_NORMAL_RST || pc_r == PC_SERIAL_RST);
  endproperty
  a_pc_held: assert property (p_pc_held) else $error("pc not at reset value");

  property p_sp;
    @(posedge sys_clk) disable iff (!reset_n) ##1 stackPointer == SP_RST;
  endproperty
  a_sp: assert property (p_sp) else $error("sp not 0x00ff");

  property p_lowosc;
    @(posedge sys_clk) disable iff (!reset_n) (phase_r != ST_RUN) |-> !lowOscEnable;
  endproperty
  a_lowosc: assert property (p_lowosc) else $error("low osc enabled early");

  property p_wdog;
    @(posedge sys_clk) disable iff (!reset_n) watchdogEnable == (phase_r == ST_RUN);
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog state wrong");

  sequence s_warm_entry;
    phase_r == ST_RESET && !anyReset ##1 phase_r == ST_WARMUP;
  endsequence
  property p_warm_len;
    @(posedge sys_clk) disable iff (anyReset)
      s_warm_entry |-> (phase_r == ST_WARMUP)[*8];
  endproperty
  a_warm_len: assert property (p_warm_len) else $error("warm-up ended early");

  property p_restart;
    @(posedge sys_clk) disable iff (!reset_n) anyReset |=> phase_r == ST_RESET;
  endproperty
  a_restart: assert property (p_restart) else $error("reset did not restart warm-up");

  property p_vector;
    @(posedge sys_clk) disable iff (!reset_n)
      (phase_r == ST_WARMUP && phase_nxt == ST_RUN) |=> vectorFetch && cpuRun;
  endproperty
  a_vector: assert property (p_vector) else $error("no vector fetch at release");

  property p_vdet;
    @(posedge sys_clk) disable iff (!reset_n) hardReset |=> !voltDetectEnable;
  endproperty
  a_vdet: assert property (p_vdet) else $error("voltage detect kept on hard reset");

  property p_vdet_keep;
    @(posedge sys_clk) disable iff (!reset_n)
      (!hardReset && rstSync_r[2] && !regWr) |=> $stable(voltDetectEnable);
  endproperty
  a_vdet_keep: assert property (p_vdet_keep) else $error("internal reset changed voltage detect");
endmodule

// File: reset_state_initializer_tb.sv
// self-checking bench for the reset state initializer
`timescale 1ns/1ps
module reset_state_initializer_tb;
  import reset_init_pkg::*;
  localparam int WU = 10;
  logic        sys_clk, reset_n, powerOnReset, pinReset, internalReset, serialProgMode;
  logic [1:0]  regAddr;
  logic [15:0] regWrData, regRdData, programCounter, stackPointer;
  logic        regWr, regRd, registerBankSelect, masterInterruptEnable, highOscEnable, lowOscEnable;
  logic        watchdogEnable, voltDetectEnable, cpuRun, vectorFetch;
  logic [7:0]  individualEnableFlags, interruptLatch, prescaler, portOutEnable;
  int          errTotal, numChecks, cyc;
  logic        vExp;
  reset_state_initializer #(.WARMUP(WU)) dut_u (
    .sys_clk               (sys_clk),
    .reset_n               (reset_n),
    .powerOnReset          (powerOnReset),
    .pinReset              (pinReset),
    .internalReset         (internalReset),
    .serialProgMode        (serialProgMode),
    .regAddr               (regAddr),
    .regWrData             (regWrData),
    .regWr                 (regWr),
    .regRd                 (regRd),
    .regRdData             (regRdData),
    .programCounter        (programCounter),
    .stackPointer          (stackPointer),
    .registerBankSelect    (registerBankSelect),
    .masterInterruptEnable (masterInterruptEnable),
    .individualEnableFlags (individualEnableFlags),
    .interruptLatch        (interruptLatch),
    .highOscEnable         (highOscEnable),
    .lowOscEnable          (lowOscEnable),
    .watchdogEnable        (watchdogEnable),
    .prescaler             (prescaler),
    .voltDetectEnable      (voltDetectEnable),
    .cpuRun                (cpuRun),
    .vectorFetch           (vectorFetch),
    .portOutEnable         (portOutEnable)
  );
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // a hang anywhere ends in the report
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 20000) begin
      errTotal++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    numChecks++;
    if (seen !== exp) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1 d = regRdData;
  endtask
  task automatic stateChk(input logic run);
    chk("pc", programCounter, serialProgMode ? PC_SERIAL_RST : PC_NORMAL_RST);
    chk("sp", stackPointer, SP_RST);
    chk("bank", 16'(registerBankSelect), 16'h0000);
    chk("imf", 16'(masterInterruptEnable), 16'h0000);
    chk("enLatch", {individualEnableFlags, interruptLatch}, 16'h0000);
    chk("hiOsc", 16'(highOscEnable), 16'h0001);
    chk("loOsc", 16'(lowOscEnable), 16'h0000);
    chk("wdog", 16'(watchdogEnable), 16'(run));
    chk("run", 16'(cpuRun), 16'(run));
    chk("presc", 16'(prescaler), 16'h0000);
    chk("port", 16'(portOutEnable), 16'h0000);
  endtask
  // src: 0 sync reset, 1 power-on, 2 pin, 3 internal; again restarts warm-up
  task automatic rstSeq(input int src, input bit again);
    int n;
    int vf;
    logic [15:0] d;
    logic v;
    @(posedge sys_clk);
    serialProgMode <= 1'($urandom % 2);
    case (src)
      0: reset_n <= 1'b0;
      1: powerOnReset <= 1'b1;
      2: pinReset <= 1'b1;
      default: internalReset <= 1'b1;
    endcase
    repeat (4) @(posedge sys_clk);
    #1 stateChk(1'b0);
    @(posedge sys_clk);
    {powerOnReset, pinReset, internalReset} <= 3'h0;
    reset_n <= 1'b1;
    n = 0;
    vf = 0;
    while (cpuRun !== 1'b1 && n < 300) begin
      @(posedge sys_clk);
      #1 n++;
      vf += int'(vectorFetch);
      if (n == 4) begin
        stateChk(1'b0);
        // early write must not wake the slow oscillator
        wr(REG_CTRL, 16'h0001);
        n++;
      end
      if (again && n == 6) begin
        again = 1'b0;
        // a pin reset clears voltage detect whatever the first cause was
        vExp = 1'b0;
        pinReset <= 1'b1;
        repeat (3) @(posedge sys_clk);
        pinReset <= 1'b0;
        n = 0;
        vf = 0;
      end
    end
    chk("warmLen", 16'(n >= WU && n <= WU + 6), 16'h0001);
    stateChk(1'b1);
    @(posedge sys_clk);
    #1 vf += int'(vectorFetch);
    chk("vecPulse", 16'(vf), 16'h0001);
    rd(REG_STATUS, d);
    chk("status", d, 16'h0004);
    rd(REG_PC, d);
    chk("pcReg", d, serialProgMode ? PC_SERIAL_RST : PC_NORMAL_RST);
    if (src != 3) vExp = 1'b0;
    rd(REG_VDET, d);
    chk("vdetReg", d, {15'h0, vExp});
    chk("vdetPin", 16'(voltDetectEnable), 16'(vExp));
    rd(REG_CTRL, d);
    chk("ctrl", d, {14'h0, vExp, 1'b0});
    v = 1'($urandom % 2);
    wr(REG_VDET, {15'h0, v});
    rd(REG_VDET, d);
    vExp = v;
    chk("vdetWr", d, {15'h0, v});
  endtask
  initial begin
    void'($urandom(65745));
    {reset_n, powerOnReset, pinReset, internalReset, serialProgMode} = 5'h00;
    {regAddr, regWrData, regWr, regRd} = '0;
    errTotal = 0;
    numChecks = 0;
    cyc = 0;
    vExp = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rstSeq(i % 4, i >= 4);
    end
    complete_run();
  end
endmodule
